// file: verilog/servo_pid_control_loop.sv
/*
  Per-axis servo loop: forms PID, velocity feedback and velocity
  feedforward terms into a saturated 16-bit amplifier command.
  Assumes trajectory and encoder inputs are synchronous to mclk.
*/
`timescale 1ns/100ps
// How it works
// [RQ1] Error times proportional gain each sample
// [RQ2] Accumulate position error every sample period
// [RQ3] Integration sum divided by 256 first
// [RQ4] Integral gain resets to zero
// [RQ5] Integration limit clamps integral contribution
// [RQ6] Error derivative times gain per derivative period
// [RQ7] Software keeps derivative gain nonzero for torque
// [RQ8] Nonzero gain enables velocity feedback, secondary preferred
// [RQ9] Scaled encoder velocity added to command; the code subtracts it
// [RQ10] Estimate per derivative, apply per sample
// [RQ11] Velocity from time between encoder counts
// [RQ12] Feedforward gain times trajectory velocity added
// [RQ13] Feedforward gain changes apply any time
// [RQ14] Three loop structures are selectable
// [RQ15] Feedforward structure zeroes derivative and velocity gains
// [RQ16] Command saturates to signed 16-bit range
module servo_pid_control_loop (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic signed [servo_loop_pkg::POS_W-1:0] trajectory_position,
  input wire logic signed [servo_loop_pkg::POS_W-1:0] trajectory_velocity,
  input wire logic signed [servo_loop_pkg::POS_W-1:0] feedback_position,
  input wire logic primary_count_pulse,
  input wire logic primary_count_dir,
  input wire logic secondary_count_pulse,
  input wire logic secondary_count_dir,
  input wire logic secondary_configured,
  input wire servo_loop_pkg::loop_mode_type loop_mode,
  input wire logic gain_write,
  input wire logic signed [servo_loop_pkg::GAIN_W-1:0] proportional_gain,
  input wire logic signed [servo_loop_pkg::GAIN_W-1:0] integral_gain,
  input wire logic signed [servo_loop_pkg::GAIN_W-1:0] derivative_gain,
  input wire logic signed [servo_loop_pkg::GAIN_W-1:0] velocity_feedback_gain,
  input wire logic signed [servo_loop_pkg::GAIN_W-1:0] feedforward_gain,
  input wire logic [servo_loop_pkg::GAIN_W-1:0] integration_limit,
  output logic signed [servo_loop_pkg::CMD_W-1:0] dac_command,
  output logic sample_strobe,
  output logic [1:0] active_mode
);
  import servo_loop_pkg::*;

  localparam int unsigned ACC_W = 56;

  logic [PERIOD_W-1:0] sample_cnt_reg;
  logic [PERIOD_W-1:0] deriv_cnt_reg;
  logic sample_tick;
  logic deriv_tick;
  logic signed [GAIN_W-1:0] kp_reg, ki_reg, kd_reg, kv_reg, kff_reg;
  logic [GAIN_W-1:0] ilimit_reg;
  loop_mode_type mode_reg;
  logic signed [POS_W-1:0] error;
  logic signed [INTEG_W-1:0] integ_reg;
  logic signed [POS_W-1:0] last_deriv_error_reg;
  logic signed [ACC_W-1:0] deriv_term_reg;
  logic signed [VEL_W-1:0] vel_primary;
  logic signed [VEL_W-1:0] vel_secondary;
  logic signed [VEL_W-1:0] vel_sel;
  logic signed [ACC_W-1:0] velfb_est_reg;
  logic signed [ACC_W-1:0] velfb_term_reg;
  logic signed [ACC_W-1:0] p_term, i_term, ff_term, sum;
  logic signed [ACC_W-1:0] ilim_wide;
  logic signed [GAIN_W-1:0] kd_eff, kv_eff;

  // Wide signed product, sized so no gain/error combination overflows
  function automatic logic signed [ACC_W-1:0] scale(input logic signed [POS_W+8-1:0] value,
                                                    input logic signed [GAIN_W-1:0] gain);
    scale = ACC_W'(value * gain);
  endfunction

  function automatic logic signed [CMD_W-1:0] saturate(input logic signed [ACC_W-1:0] value);
    if (value > ACC_W'(CMD_MAX))
      saturate = CMD_MAX;
    else if (value < ACC_W'(CMD_MIN))
      saturate = CMD_MIN;
    else
      saturate = value[CMD_W-1:0];
  endfunction

  assign sample_tick = (sample_cnt_reg == PERIOD_W'(SAMPLE_CYCLES - 1));
  assign deriv_tick = (deriv_cnt_reg == PERIOD_W'(DERIV_CYCLES - 1));

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sample_cnt_reg <= '0;
      deriv_cnt_reg <= '0;
    end else begin
      sample_cnt_reg <= sample_tick ? '0 : sample_cnt_reg + 1'b1;
      deriv_cnt_reg <= deriv_tick ? '0 : deriv_cnt_reg + 1'b1;
    end
  end

  // Gains load on gain_write at any time; the loop uses them from the next tick
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      kp_reg <= GAIN_RESET;
      ki_reg <= GAIN_RESET; // [RQ4]
      kd_reg <= GAIN_RESET;
      kv_reg <= GAIN_RESET;
      kff_reg <= GAIN_RESET;
      ilimit_reg <= GAIN_RESET;
      mode_reg <= pid_loop_mode;
    end else if (gain_write) begin // [RQ13]
      kp_reg <= proportional_gain;
      ki_reg <= integral_gain;
      kd_reg <= derivative_gain;
      kv_reg <= velocity_feedback_gain;
      kff_reg <= feedforward_gain; // [RQ13]
      ilimit_reg <= integration_limit;
      mode_reg <= loop_mode; // [RQ14]
    end
  end

  // Derivative and velocity feedback are forced off in the feedforward structure
  always_comb begin
    kd_eff = (mode_reg == velocity_feedforward_loop_mode) ? '0 : kd_reg; // [RQ15]
    kv_eff = (mode_reg == velocity_feedforward_loop_mode || mode_reg == pid_loop_mode)
             ? '0 : kv_reg; // [RQ14] [RQ15]
  end

  assign error = trajectory_position - feedback_position; // [RQ1]

  // Integration sum is not clamped and wraps at 40 bits; limit applies to the output term
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      integ_reg <= '0;
    end else if (sample_tick) begin
      integ_reg <= integ_reg + INTEG_W'(error); // [RQ2]
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      last_deriv_error_reg <= '0;
      deriv_term_reg <= '0;
    end else if (deriv_tick) begin // [RQ6]
      last_deriv_error_reg <= error;
      deriv_term_reg <= scale(40'(error) - 40'(last_deriv_error_reg), kd_eff);
    end
  end

  velocity_estimator primary_est (
    .mclk(mclk),
    .resetn(resetn),
    .count_pulse(primary_count_pulse),
    .count_dir(primary_count_dir),
    .window_tick(deriv_tick),
    .velocity(vel_primary)
  );

  velocity_estimator secondary_est (
    .mclk(mclk),
    .resetn(resetn),
    .count_pulse(secondary_count_pulse),
    .count_dir(secondary_count_dir),
    .window_tick(deriv_tick),
    .velocity(vel_secondary)
  );

  assign vel_sel = secondary_configured ? vel_secondary : vel_primary; // [RQ8]

  // Estimate refreshes each derivative period, command term only on sample ticks
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      velfb_est_reg <= '0;
      velfb_term_reg <= '0;
    end else begin
      if (deriv_tick)
        velfb_est_reg <= (kv_eff != '0) ? scale(40'(vel_sel), kv_eff) : '0; // [RQ8] [RQ9]
      if (sample_tick)
        velfb_term_reg <= velfb_est_reg; // [RQ10]
    end
  end

  always_comb begin
    p_term = scale(40'(error), kp_reg); // [RQ1]
    i_term = scale(40'(integ_reg >>> INTEG_SHIFT), ki_reg); // [RQ3]
    ilim_wide = ACC_W'({1'b0, ilimit_reg});
    if (i_term > ilim_wide) // [RQ5]
      i_term = ilim_wide;
    else if (i_term < -ilim_wide)
      i_term = -ilim_wide;
    ff_term = scale(40'(trajectory_velocity), kff_reg); // [RQ12]
    // Velocity feedback opposes motion, hence the subtraction
    sum = p_term + i_term + deriv_term_reg - velfb_term_reg + ff_term; // [RQ9]
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dac_command <= CMD_RESET;
      sample_strobe <= 1'b0;
      active_mode <= 2'h0;
    end else begin
      sample_strobe <= sample_tick;
      active_mode <= mode_reg;
      if (sample_tick)
        dac_command <= saturate(sum); // [RQ16]
    end
  end

endmodule

// file: common/servo_loop_pkg.sv
/*
  Shared constants and types for the per-axis servo loop.
  Assumes a single 10 MHz clock domain and plain-port configuration.
*/
package servo_loop_pkg;

  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned POS_W = 32;
  localparam int unsigned GAIN_W = 16;
  localparam int unsigned CMD_W = 16;
  localparam int unsigned INTEG_W = 40;
  localparam int unsigned INTEG_SHIFT = 8;
  localparam int unsigned PERIOD_W = 16;

  // Sample periods in microseconds, converted to cycle counts below
  localparam int unsigned SAMPLE_PERIOD_US = 62;
  localparam int unsigned DERIV_PERIOD_US = 62;
  localparam int unsigned SAMPLE_CYCLES = SAMPLE_PERIOD_US * (CLK_HZ / 1000000);
  localparam int unsigned DERIV_CYCLES = DERIV_PERIOD_US * (CLK_HZ / 1000000);

  localparam logic [GAIN_W-1:0] GAIN_RESET = 16'h0000;
  localparam logic [CMD_W-1:0] CMD_RESET = 16'h0000;
  localparam logic signed [CMD_W-1:0] CMD_MAX = 16'sh7fff;
  localparam logic signed [CMD_W-1:0] CMD_MIN = -16'sh8000;

  // Encoder-period velocity estimator
  localparam int unsigned EDGE_TIMER_W = 16;
  localparam logic [EDGE_TIMER_W-1:0] EDGE_TIMER_MAX = 16'hffff;
  localparam int unsigned VEL_W = 16;
  localparam int unsigned VEL_SCALE_SHIFT = 16;

  typedef enum logic [1:0] {
    pid_loop_mode,
    velocity_feedback_loop_mode,
    velocity_feedforward_loop_mode
  } loop_mode_type;

endpackage

// file: verilog/velocity_estimator.sv
/*
  Encoder velocity estimator: measures time between encoder counts and
  switches to a count-per-window estimate at high speed.
  Assumes count pulses are single-cycle and synchronous to mclk.
*/
`timescale 1ns/100ps
module velocity_estimator (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic count_pulse,
  input wire logic count_dir,
  input wire logic window_tick,
  output logic signed [servo_loop_pkg::VEL_W-1:0] velocity
);
  import servo_loop_pkg::*;

  logic [EDGE_TIMER_W-1:0] interval_reg;
  logic [EDGE_TIMER_W-1:0] last_interval_reg;
  logic last_dir_reg;
  logic [VEL_W-1:0] window_count_reg;
  logic signed [VEL_W-1:0] window_vel;
  logic signed [VEL_W-1:0] period_vel;
  logic [VEL_W-1:0] period_mag;

  // Cycles elapsed between successive counts; saturates when stopped
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      interval_reg <= '0;
      last_interval_reg <= EDGE_TIMER_MAX;
      last_dir_reg <= 1'b0;
    end else if (count_pulse) begin // [RQ11]
      last_interval_reg <= interval_reg;
      last_dir_reg <= count_dir;
      interval_reg <= '0;
    end else if (interval_reg != EDGE_TIMER_MAX) begin
      interval_reg <= interval_reg + 1'b1;
    end else begin
      last_interval_reg <= EDGE_TIMER_MAX;
    end
  end

  // Signed counts seen inside one derivative window
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      window_count_reg <= '0;
    end else if (window_tick) begin
      window_count_reg <= count_pulse ? (count_dir ? 16'hffff : 16'h0001) : 16'h0000;
    end else if (count_pulse) begin
      window_count_reg <= count_dir ? window_count_reg - 1'b1 : window_count_reg + 1'b1;
    end
  end

  always_comb begin
    // A stalled timer means the shaft stopped, so it must not read as a slow crawl
    if (last_interval_reg == EDGE_TIMER_MAX)
      period_mag = '0;
    else if (last_interval_reg == '0)
      period_mag = 16'hffff;
    else
      period_mag = VEL_W'(32'h0000ffff / {16'h0000, last_interval_reg});
    period_vel = last_dir_reg ? -$signed(period_mag) : $signed(period_mag);
    window_vel = $signed(window_count_reg);
  end

  // Low speed trusts edge timing; fast motion trusts the window count
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      velocity <= '0;
    end else if (window_tick) begin // [RQ10] [RQ11]
      if (window_vel > 16'sd1 || window_vel < -16'sd1)
        velocity <= window_vel <<< 4;
      else
        velocity <= period_vel;
    end
  end

endmodule

// file: tb/servo_far_side.sv
/* Far-side model: trajectory source and encoders.
   Assumes the bench sets lag, velocity and motion by NBA. */
`timescale 1ns/100ps
module servo_far_side (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic signed [servo_loop_pkg::POS_W-1:0] lag,
  input wire logic signed [servo_loop_pkg::POS_W-1:0] vel,
  input wire logic moving,
  output logic signed [servo_loop_pkg::POS_W-1:0] trajectory_position,
  output logic signed [servo_loop_pkg::POS_W-1:0] trajectory_velocity,
  output logic signed [servo_loop_pkg::POS_W-1:0] feedback_position,
  output logic primary_count_pulse,
  output logic primary_count_dir,
  output logic secondary_count_pulse,
  output logic secondary_count_dir
);
  import servo_loop_pkg::*;
  logic [4:0] tick_reg;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tick_reg <= 5'h00;
      primary_count_pulse <= 1'b0;
      secondary_count_pulse <= 1'b0;
    end else begin
      tick_reg <= tick_reg + 5'h01;
      // Encoder pulses are single-cycle, the secondary at half rate
      primary_count_pulse <= moving && tick_reg[3:0] == 4'h0;
      secondary_count_pulse <= moving && tick_reg == 5'h00;
    end
  end
  assign primary_count_dir = 1'b0;
  assign secondary_count_dir = 1'b0;
  // Fixed setpoint keeps the error equal to lag
  assign trajectory_position = 32'sh0000_1000;
  assign trajectory_velocity = vel;
  assign feedback_position = trajectory_position - lag;
endmodule

// file: tb/servo_pid_control_loop_sva.sv
/* Port checker for the servo loop.
   Assumes one clock domain and bind to every loop instance. */
`timescale 1ns/100ps
module servo_loop_sva (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic gain_write,
  input wire servo_loop_pkg::loop_mode_type loop_mode,
  input wire logic signed [servo_loop_pkg::CMD_W-1:0] dac_command,
  input wire logic sample_strobe,
  input wire logic [1:0] active_mode
);
  import servo_loop_pkg::*;
  logic loaded_reg;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      loaded_reg <= 1'b0;
    end else if (gain_write) begin
      loaded_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  sequence quiet_gap;
    !sample_strobe [*8];
  endsequence
  a_strobe_single: assert property (sample_strobe |=> quiet_gap)
    else $error("strobe lasted more than one cycle");
  a_strobe_period: assert property (sample_strobe |-> ##[620:620] sample_strobe)
    else $error("sample period is not 620 cycles");
  a_cmd_hold: assert property (!sample_strobe |-> $stable(dac_command))
    else $error("command moved outside a strobe");
  a_mode_load: assert property (gain_write |-> ##2
    active_mode == 2'($past(loop_mode, 2)))
    else $error("mode not loaded by gain write");
  a_mode_keep: assert property (!gain_write |-> ##2 $stable(active_mode))
    else $error("mode changed without gain write");
  a_idle_cmd: assert property (!loaded_reg |-> dac_command == 16'sh0000)
    else $error("command nonzero before any gains");
  a_idle_mode: assert property (!loaded_reg |-> active_mode == 2'h0)
    else $error("mode nonzero before any load");
  a_mode_legal: assert property (active_mode != 2'h3)
    else $error("undefined loop structure");
endmodule
bind servo_pid_control_loop servo_loop_sva i_sva (.mclk, .resetn, .gain_write,
  .loop_mode, .dac_command, .sample_strobe, .active_mode);

// file: tb/tb_servo_pid_control_loop.sv
/* Self-checking bench for the servo loop.
   Assumes gains take effect within three sample strobes. */
`timescale 1ns/100ps
module tb_servo_pid_control_loop;
  import servo_loop_pkg::*;
  logic mclk = 1'b0, resetn = 1'b0, gain_write = 1'b0, moving = 1'b0;
  logic secondary_configured = 1'b0, sample_strobe;
  logic primary_count_pulse, primary_count_dir, secondary_count_pulse, secondary_count_dir;
  loop_mode_type loop_mode = pid_loop_mode;
  logic signed [GAIN_W-1:0] proportional_gain = '0, integral_gain = '0, derivative_gain = '0;
  logic signed [GAIN_W-1:0] velocity_feedback_gain = '0, feedforward_gain = '0;
  logic [GAIN_W-1:0] integration_limit = '0;
  logic signed [POS_W-1:0] lag = 32'sd500, vel = '0;
  logic signed [POS_W-1:0] trajectory_position, trajectory_velocity, feedback_position;
  logic signed [CMD_W-1:0] dac_command;
  logic [1:0] active_mode;
  int n_fail = 0, check_count = 0;
  always #50 mclk = ~mclk;
  servo_far_side i_far (.mclk, .resetn, .lag, .vel, .moving, .trajectory_position,
    .trajectory_velocity, .feedback_position, .primary_count_pulse, .primary_count_dir,
    .secondary_count_pulse, .secondary_count_dir);
  servo_pid_control_loop i_dut (.mclk, .resetn, .trajectory_position, .trajectory_velocity,
    .feedback_position, .primary_count_pulse, .primary_count_dir, .secondary_count_pulse,
    .secondary_count_dir, .secondary_configured, .loop_mode, .gain_write, .proportional_gain,
    .integral_gain, .derivative_gain, .velocity_feedback_gain, .feedforward_gain,
    .integration_limit, .dac_command, .sample_strobe, .active_mode);
  task automatic conclude();
    $display("Checks %0d, errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wait_strobe();
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (sample_strobe !== 1'b1 && n < 700);
    if (n >= 700) begin
      n_fail++;
      $display("Error at %0t: no sample strobe", $time);
      conclude();
    end
  endtask
  task automatic compare(input logic signed [CMD_W-1:0] exp_cmd, input loop_mode_type m);
    check_count++;
    if (dac_command !== exp_cmd || active_mode !== 2'(m)) begin
      n_fail++;
      $display("Error at %0t: command %0d mode %0d, expected %0d", $time, dac_command,
        active_mode, exp_cmd);
    end
  endtask
  // Loads a full gain set, then checks the command three strobes later
  task automatic run(input loop_mode_type m, input int p, i, d, v, f, l, e, s,
    input logic signed [CMD_W-1:0] exp_cmd);
    @(posedge mclk);
    loop_mode <= m;
    proportional_gain <= GAIN_W'(p);
    integral_gain <= GAIN_W'(i);
    derivative_gain <= GAIN_W'(d);
    velocity_feedback_gain <= GAIN_W'(v);
    feedforward_gain <= GAIN_W'(f);
    integration_limit <= GAIN_W'(l);
    lag <= e;
    vel <= s;
    moving <= v != 0;
    secondary_configured <= v != 0;
    gain_write <= 1'b1;
    @(posedge mclk);
    gain_write <= 1'b0;
    repeat (3) wait_strobe();
    compare(exp_cmd, m);
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) wait_strobe();
    compare(16'sh0000, pid_loop_mode);
    run(pid_loop_mode, 3, 0, 0, 0, 0, 0, 100, 0, 16'sh012c);
    run(pid_loop_mode, -2, 0, 0, 500, 0, 0, 100, 0, 16'shff38);
    run(velocity_feedback_loop_mode, 1, 0, 0, 0, 0, 0, 10, 0, 16'sh000a);
    run(velocity_feedforward_loop_mode, 1, 0, 200, 300, 5, 0, 10, 7, 16'sh002d);
    run(velocity_feedforward_loop_mode, 1, 0, 200, 300, 6, 0, 10, 7, 16'sh0034);
    run(pid_loop_mode, 32767, 0, 0, 0, 0, 0, 100, 0, 16'sh7fff);
    run(pid_loop_mode, 32767, 0, 0, 0, 0, 0, -100, 0, 16'sh8000);
    run(pid_loop_mode, 0, 1000, 0, 0, 0, 50, 1000, 0, 16'sh0032);
    run(pid_loop_mode, 0, 1000, 0, 0, 0, 50, -20000, 0, 16'shffce);
    run(pid_loop_mode, 1, 0, 40, 0, 0, 0, 100, 0, 16'sh0064);
    // A step in lag shows up as damping two derivative periods later, at the second strobe
    @(posedge mclk);
    lag <= 32'sd110;
    repeat (2) wait_strobe();
    compare(16'sh01fe, pid_loop_mode);
    // Mid-run reset restarts integrator, dividers and encoders in step
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    run(velocity_feedback_loop_mode, 0, 3, 0, 10, 0, 1000, 1280, 0, 16'sh001e);
    wait_strobe();
    compare(16'shf44d, velocity_feedback_loop_mode);
    conclude();
  end
endmodule
